// *** hdl/ris_pkg.sv ***
// shared constants for the remappable input select bank
package ris_pkg;

  // field and bank geometry
  localparam int unsigned CODE_W = 5;
  localparam int unsigned NUM_PINS = 32;
  localparam int unsigned NUM_REGS = 9;
  localparam int unsigned NUM_SLOTS = 18;
  localparam int unsigned REG_W = 16;
  localparam int unsigned LO_LSB = 0;
  localparam int unsigned HI_LSB = 8;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SYNC_STAGES = 2;

  typedef logic [CODE_W-1:0] ris_code_t;
  typedef logic [3:0] ris_reg_idx_t;

  // register byte addresses on the bus
  localparam logic [ADDR_W-1:0] ADDR_CAP_A = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_CAP_B = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_CAP_C = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_FAULT = 12'h00C;
  localparam logic [ADDR_W-1:0] ADDR_SER1 = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_SER2 = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_SYNC1 = 12'h018;
  localparam logic [ADDR_W-1:0] ADDR_SYNC1_SEL = 12'h01C;
  localparam logic [ADDR_W-1:0] ADDR_SYNC2 = 12'h020;
  localparam logic [ADDR_W-1:0] ADDR_LOCK = 12'h024;
  localparam logic [ADDR_W-1:0] ADDR_PINS = 12'h028;

  // register indices used by the decoder
  localparam ris_reg_idx_t IDX_LOCK = 4'h9;
  localparam ris_reg_idx_t IDX_PINS = 4'hA;
  localparam ris_reg_idx_t IDX_NONE = 4'hF;

  // reset value of every implemented select field
  localparam ris_code_t CODE_RESET = 5'h1F;
  localparam logic LOCK_RESET = 1'b0;
  localparam int unsigned LOCK_BIT = 0;

  // slot k sits in register k/2, low field if k even, high field if odd
  localparam logic [NUM_SLOTS-1:0] SLOT_USED = 18'h3_7FDF;
  localparam int unsigned SLOT_CAP1 = 0;
  localparam int unsigned SLOT_CAP2 = 1;
  localparam int unsigned SLOT_CAP3 = 2;
  localparam int unsigned SLOT_CAP4 = 3;
  localparam int unsigned SLOT_CAP5 = 4;
  localparam int unsigned SLOT_FLT_A = 6;
  localparam int unsigned SLOT_FLT_B = 7;
  localparam int unsigned SLOT_SER1_RX = 8;
  localparam int unsigned SLOT_SER1_CTS = 9;
  localparam int unsigned SLOT_SER2_RX = 10;
  localparam int unsigned SLOT_SER2_CTS = 11;
  localparam int unsigned SLOT_SYNC1_DIN = 12;
  localparam int unsigned SLOT_SYNC1_CLK = 13;
  localparam int unsigned SLOT_SYNC1_SEL = 14;
  localparam int unsigned SLOT_SYNC2_DIN = 16;
  localparam int unsigned SLOT_SYNC2_CLK = 17;

endpackage

// *** hdl/ris_pin_select.sv ***
// one routing lane: picks the pin named by a select code
`timescale 1ns/1ps
`default_nettype none
module ris_pin_select
  import ris_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ris_pkg::NUM_PINS-1:0] pins,
  input wire ris_pkg::ris_code_t code,
  output logic level
);
  import ris_pkg::*;

  logic level_r;
  logic level_nxt;

  // exactly one pin feeds the lane, named by the code
  assign level_nxt = pins[code];

  // registered so the peripheral sees a clean level
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level_r <= 1'b0;
    end
    else
    begin
      level_r <= level_nxt;
    end
  end

  assign level = level_r;

endmodule
`default_nettype wire

// *** hdl/ris_select_bank.sv ***
// remappable input select bank with apb register access
//
// How it works
// - capture 1 from select A bits 4-0, capture 2 from bits 12-8
// - capture 3 from select B bits 4-0, capture 4 from bits 12-8
// - capture 5 from select C bits 4-0; bits 15-5 unused
// - fault A from fault select bits 4-0, fault B from bits 12-8
// - serial one receive from bits 4-0, clear-to-send from bits 12-8
// - serial two receive from bits 4-0, clear-to-send from bits 12-8
// - sync one data from bits 4-0, clock from bits 12-8
// - sync one slave select from its own register bits 4-0
// - sync two data from bits 4-0, clock from bits 12-8
// - unused bits read zero and ignore writes
// - every select field resets to all ones and is read/write
// - a field value n routes remappable pin n to its input
// - mapping writes accepted only while the mapping lock is clear
`timescale 1ns/1ps
`default_nettype none
module ris_select_bank
  import ris_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ris_pkg::ADDR_W-1:0] PADDR,
  input wire logic [ris_pkg::DATA_W-1:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic PREADY,
  output logic [ris_pkg::DATA_W-1:0] PRDATA,
  output logic PSLVERR,
  input wire logic [ris_pkg::NUM_PINS-1:0] REMAPPABLE_PIN,
  output logic MAPPING_LOCK,
  output logic CAPTURE1_IN,
  output logic CAPTURE2_IN,
  output logic CAPTURE3_IN,
  output logic CAPTURE4_IN,
  output logic CAPTURE5_IN,
  output logic COMPARE_FAULT_A,
  output logic COMPARE_FAULT_B,
  output logic SERIAL1_RX,
  output logic SERIAL1_CTS,
  output logic SERIAL2_RX,
  output logic SERIAL2_CTS,
  output logic SYNC1_DIN,
  output logic SYNC1_CLK,
  output logic SYNC1_SEL,
  output logic SYNC2_DIN,
  output logic SYNC2_CLK
);
  import ris_pkg::*;

  // address decode: if/else chain to register index
  function automatic ris_reg_idx_t decode_addr(
    input logic [ADDR_W-1:0] addr
  );
    ris_reg_idx_t idx;
    idx = IDX_NONE;
    if (addr == ADDR_CAP_A)
      idx = 4'h0;
    else if (addr == ADDR_CAP_B)
      idx = 4'h1;
    else if (addr == ADDR_CAP_C)
      idx = 4'h2;
    else if (addr == ADDR_FAULT)
      idx = 4'h3;
    else if (addr == ADDR_SER1)
      idx = 4'h4;
    else if (addr == ADDR_SER2)
      idx = 4'h5;
    else if (addr == ADDR_SYNC1)
      idx = 4'h6;
    else if (addr == ADDR_SYNC1_SEL)
      idx = 4'h7;
    else if (addr == ADDR_SYNC2)
      idx = 4'h8;
    else if (addr == ADDR_LOCK)
      idx = IDX_LOCK;
    else if (addr == ADDR_PINS)
      idx = IDX_PINS;
    else
      idx = IDX_NONE;
    return idx;
  endfunction

  // register index of a slot
  function automatic ris_reg_idx_t slot_reg(input int unsigned slot);
    return ris_reg_idx_t'(slot / 2);
  endfunction

  // reset synchroniser: assert at once, release through two flops
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n_int;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rst_n_int = rst_sync_r;

  // pins come from outside, so two flops before anything reads them
  logic [NUM_PINS-1:0] pin_meta_r;
  logic [NUM_PINS-1:0] pin_sync_r;

  always_ff @(posedge CLK or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end
    else
    begin
      pin_meta_r <= REMAPPABLE_PIN;
      pin_sync_r <= pin_meta_r;
    end
  end

  // bus phase qualifiers
  logic setup_phase;
  logic access_phase;
  logic wr_commit;
  ris_reg_idx_t acc_idx;
  logic acc_mapped;

  assign setup_phase = PSEL && !PENABLE;
  assign access_phase = PSEL && PENABLE;
  assign wr_commit = access_phase && PWRITE;
  assign acc_idx = decode_addr(PADDR);
  assign acc_mapped = (acc_idx != IDX_NONE);

  // zero wait states: every access phase ends at its first edge
  assign PREADY = 1'b1;

  // lock bit, itself always writable so software can unlock
  logic lock_r;
  logic lock_nxt;
  logic lock_wr;

  assign lock_wr = wr_commit && (acc_idx == IDX_LOCK) && PSTRB[0];
  assign lock_nxt = lock_wr ? PWDATA[LOCK_BIT] : lock_r;

  always_ff @(posedge CLK or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      lock_r <= LOCK_RESET;
    end
    else
    begin
      lock_r <= lock_nxt;
    end
  end

  assign MAPPING_LOCK = lock_r;

  // select fields: one array entry per slot, only 5 bits kept
  ris_code_t field_r [NUM_SLOTS];
  logic [NUM_SLOTS-1:0] field_wr;
  ris_code_t field_lvl [NUM_SLOTS];
  logic [NUM_SLOTS-1:0] lane_level;

  genvar gs;
  generate
    for (gs = 0; gs < NUM_SLOTS; gs++)
    begin : g_slot
      if (SLOT_USED[gs])
      begin : g_used
        // each lane owns its code flop; the array only collects them
        ris_code_t code_r;

        // locked writes are dropped, not deferred
        // byte lane strobe gates each field separately
        assign field_wr[gs] = wr_commit && !lock_r
          && (acc_idx == slot_reg(gs)) && PSTRB[gs % 2];
        // only the 5 code bits exist; upper lane bits are lost
        assign field_lvl[gs] = (gs % 2 == 0)
          ? PWDATA[LO_LSB +: CODE_W] : PWDATA[HI_LSB +: CODE_W];

        // fields start at all ones and are read/write
        always_ff @(posedge CLK or negedge rst_n_int)
        begin
          if (!rst_n_int)
          begin
            code_r <= CODE_RESET;
          end
          else if (field_wr[gs])
          begin
            code_r <= field_lvl[gs];
          end
        end

        // one continuous driver per array element, none procedural
        assign field_r[gs] = code_r;

        // code n delivers pin n; lanes may name the same pin
        ris_pin_select u_sel (
          .clk(CLK),
          .rst_n(rst_n_int),
          .pins(pin_sync_r),
          .code(field_r[gs]),
          .level(lane_level[gs])
        );
      end
      else
      begin : g_hole
        // unimplemented high half of a single-field register
        assign field_wr[gs] = 1'b0;
        assign field_lvl[gs] = '0;
        assign field_r[gs] = '0;
        assign lane_level[gs] = 1'b0;
      end
    end
  endgenerate

  // read value of a select register, unused bits zero
  logic [REG_W-1:0] sel_rd [NUM_REGS];

  genvar gr;
  generate
    for (gr = 0; gr < NUM_REGS; gr++)
    begin : g_rd
      assign sel_rd[gr] = {3'h0, field_r[2*gr+1], 3'h0, field_r[2*gr]};
    end
  endgenerate

  // read data and error, captured in setup so access shows flops
  logic [DATA_W-1:0] rd_value;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic slverr_r;
  logic slverr_nxt;

  assign rd_value = (acc_idx < ris_reg_idx_t'(NUM_REGS))
    ? {16'h0000, sel_rd[acc_idx[3:0]]}
    : (acc_idx == IDX_LOCK) ? {31'h0000_0000, lock_r}
    : (acc_idx == IDX_PINS) ? pin_sync_r
    : 32'h0000_0000;
  assign rdata_nxt = (setup_phase && !PWRITE) ? rd_value : rdata_r;
  // unmapped address answers with an error, nothing is stored
  assign slverr_nxt = setup_phase ? !acc_mapped : slverr_r;

  always_ff @(posedge CLK or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      rdata_r <= '0;
      slverr_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      slverr_r <= slverr_nxt;
    end
  end

  assign PRDATA = rdata_r;
  assign PSLVERR = slverr_r && access_phase;

  // peripheral inputs, each from exactly one lane
  assign CAPTURE1_IN = lane_level[SLOT_CAP1];
  assign CAPTURE2_IN = lane_level[SLOT_CAP2];
  assign CAPTURE3_IN = lane_level[SLOT_CAP3];
  assign CAPTURE4_IN = lane_level[SLOT_CAP4];
  assign CAPTURE5_IN = lane_level[SLOT_CAP5];
  assign COMPARE_FAULT_A = lane_level[SLOT_FLT_A];
  assign COMPARE_FAULT_B = lane_level[SLOT_FLT_B];
  assign SERIAL1_RX = lane_level[SLOT_SER1_RX];
  assign SERIAL1_CTS = lane_level[SLOT_SER1_CTS];
  assign SERIAL2_RX = lane_level[SLOT_SER2_RX];
  assign SERIAL2_CTS = lane_level[SLOT_SER2_CTS];
  assign SYNC1_DIN = lane_level[SLOT_SYNC1_DIN];
  assign SYNC1_CLK = lane_level[SLOT_SYNC1_CLK];
  assign SYNC1_SEL = lane_level[SLOT_SYNC1_SEL];
  assign SYNC2_DIN = lane_level[SLOT_SYNC2_DIN];
  assign SYNC2_CLK = lane_level[SLOT_SYNC2_CLK];

endmodule
`default_nettype wire

// *** sim/ris_select_bank_properties.sv ***
// port-level checks for the remappable input select bank
`timescale 1ns/1ps
`default_nettype none
module ris_select_bank_properties
  import ris_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ris_pkg::ADDR_W-1:0] PADDR,
  input wire logic [ris_pkg::DATA_W-1:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [ris_pkg::DATA_W-1:0] PRDATA,
  input wire logic PSLVERR,
  input wire logic [ris_pkg::NUM_PINS-1:0] REMAPPABLE_PIN,
  input wire logic MAPPING_LOCK,
  input wire logic CAPTURE1_IN
);
  wire logic acc;
  wire logic rd;
  wire logic lk_wr;
  wire logic c1_wr;
  wire logic unm;
  wire logic two;
  ris_code_t c1_r;
  logic [2:0] cnt_r;
  // bus decode seen from outside
  assign acc = PSEL && PENABLE;
  assign rd = acc && !PWRITE;
  assign lk_wr = acc && PWRITE && PADDR == ADDR_LOCK && PSTRB[0];
  assign c1_wr = acc && PWRITE && PADDR == ADDR_CAP_A && PSTRB[0];
  assign unm = PADDR > ADDR_PINS;
  assign two = PADDR != ADDR_CAP_C && PADDR != ADDR_SYNC1_SEL;
  // shadow of capture 1 code; locked writes must not land
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      c1_r <= CODE_RESET;
    else if (c1_wr && !MAPPING_LOCK)
      c1_r <= PWDATA[4:0];
  // cycles since reset, so the pin pipeline has refilled
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      cnt_r <= 3'h0;
    else if (cnt_r != 3'h7)
      cnt_r <= cnt_r + 3'h1;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  property p_two_zero;
    rd && PADDR <= ADDR_SYNC2 && two |-> PRDATA[31:13] == 0 && PRDATA[7:5] == 0;
  endproperty
  a_two_zero: assert property (p_two_zero) else $error("spare bits set");
  property p_one_zero;
    rd && !two |-> PRDATA[31:5] == 0;
  endproperty
  a_one_zero: assert property (p_one_zero) else $error("spare bits set");
  property p_lock_wr;
    lk_wr |=> MAPPING_LOCK == $past(PWDATA[0]);
  endproperty
  a_lock_wr: assert property (p_lock_wr) else $error("lock not written");
  property p_lock_hold;
    !lk_wr |=> $stable(MAPPING_LOCK);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock moved");
  property p_rd_code;
    rd && PADDR == ADDR_CAP_A |-> PRDATA[4:0] == c1_r;
  endproperty
  a_rd_code: assert property (p_rd_code) else $error("code readback");
  property p_route1;
    $stable(c1_r) [*3] ##0 cnt_r == 3'h7 |->
      CAPTURE1_IN == $past(REMAPPABLE_PIN[c1_r], 3);
  endproperty
  a_route1: assert property (p_route1) else $error("capture 1 route");
  property p_unm_err;
    acc && unm |-> PSLVERR;
  endproperty
  a_unm_err: assert property (p_unm_err) else $error("no error flag");
  property p_unm_zero;
    rd && unm |-> PRDATA == 0;
  endproperty
  a_unm_zero: assert property (p_unm_zero) else $error("unmapped data");
  c_lock: cover property (lk_wr && PWDATA[0]);
  c_unm: cover property (acc && unm);
  c_route: cover property (cnt_r == 3'h7 && $rose(CAPTURE1_IN));
endmodule
bind ris_select_bank ris_select_bank_properties i_props (.*);
`default_nettype wire

// *** sim/ris_select_bank_tb.sv ***
// self-checking bench for the remappable input select bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("Error at %0t: got %h want %h", $time, a, b); end end
module ris_select_bank_tb;
  import ris_pkg::*;
  logic CLK = 0;
  logic RST_N = 0;
  logic PSEL = 0;
  logic PENABLE = 0;
  logic PWRITE = 0;
  logic [ADDR_W-1:0] PADDR = '0;
  logic [DATA_W-1:0] PWDATA = '0;
  logic [3:0] PSTRB = '0;
  logic [NUM_PINS-1:0] REMAPPABLE_PIN = '0;
  wire logic [DATA_W-1:0] PRDATA;
  wire logic PREADY, PSLVERR, MAPPING_LOCK, CAPTURE1_IN, CAPTURE2_IN;
  wire logic CAPTURE3_IN, CAPTURE4_IN, CAPTURE5_IN, COMPARE_FAULT_A;
  wire logic COMPARE_FAULT_B, SERIAL1_RX, SERIAL1_CTS, SERIAL2_RX;
  wire logic SERIAL2_CTS, SYNC1_DIN, SYNC1_CLK, SYNC1_SEL, SYNC2_DIN;
  wire logic SYNC2_CLK;
  wire logic [15:0] outs;
  int miscompares = 0;
  int n_compared = 0;
  logic [31:0] rd;
  logic er;
  // register of each output, and which outputs sit in the high field
  int rg[16] = '{0, 0, 1, 1, 2, 3, 3, 4, 4, 5, 5, 6, 6, 7, 8, 8};
  logic [15:0] hm = 16'b1001_0101_0100_1010;
  assign outs = {SYNC2_CLK, SYNC2_DIN, SYNC1_SEL, SYNC1_CLK, SYNC1_DIN,
    SERIAL2_CTS, SERIAL2_RX, SERIAL1_CTS, SERIAL1_RX, COMPARE_FAULT_B,
    COMPARE_FAULT_A, CAPTURE5_IN, CAPTURE4_IN, CAPTURE3_IN, CAPTURE2_IN,
    CAPTURE1_IN};
  ris_select_bank i_dut (.*);
  initial forever #10 CLK = ~CLK;
  function automatic logic [31:0] msk(int r);
    return (r == 2 || r == 7) ? 32'h0000_001F : 32'h0000_1F1F;
  endfunction
  // one apb transfer; the gap cycle keeps setups apart
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s);
    @(posedge CLK);
    PSEL <= 1;
    PENABLE <= 0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= s;
    @(posedge CLK);
    PENABLE <= 1;
    @(posedge CLK);
    // no limit here: only the watchdog ends a stalled wait
    while (PREADY !== 1'b1)
    begin
      @(posedge CLK);
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task automatic t_regs();
    for (int r = 0; r < 9; r++)
    begin
      apb(0, 12'(4 * r), 0, 0);
      `CHK(rd, msk(r))
      apb(1, 12'(4 * r), 32'hFFFF_FFFF, 4'hF);
      apb(0, 12'(4 * r), 0, 0);
      `CHK(rd, msk(r))
      apb(1, 12'(4 * r), 0, 4'hF);
      apb(0, 12'(4 * r), 0, 0);
      `CHK(rd, 32'h0)
    end
  endtask
  // each output gets its own pin; pin 2j+1 must reach output j only
  task automatic t_route();
    logic [31:0] w[9];
    w = '{default: 0};
    for (int j = 0; j < 16; j++)
      w[rg[j]] |= 32'(2 * j + 1) << (hm[j] ? 8 : 0);
    for (int r = 0; r < 9; r++)
      apb(1, 12'(4 * r), w[r], 4'h3);
    for (int j = 0; j < 16; j++)
    begin
      REMAPPABLE_PIN <= 32'h1 << (2 * j + 1);
      repeat (4) @(posedge CLK);
      `CHK(outs, 16'h1 << j)
    end
  endtask
  task automatic t_share();
    for (int r = 0; r < 9; r++)
      apb(1, 12'(4 * r), 0, 4'h3);
    REMAPPABLE_PIN <= 32'h0000_0001;
    repeat (4) @(posedge CLK);
    `CHK(outs, 16'hFFFF)
    apb(0, ADDR_PINS, 0, 0);
    `CHK(rd, 32'h0000_0001)
    REMAPPABLE_PIN <= 32'hFFFF_FFFE;
    repeat (4) @(posedge CLK);
    `CHK(outs, 16'h0000)
  endtask
  task automatic t_lock();
    apb(1, ADDR_LOCK, 1, 4'h1);
    apb(1, ADDR_CAP_A, 32'h0000_1F1F, 4'h3);
    `CHK(MAPPING_LOCK, 1'b1)
    apb(0, ADDR_LOCK, 0, 0);
    `CHK(rd, 32'h0000_0001)
    apb(0, ADDR_CAP_A, 0, 0);
    `CHK(rd, 32'h0)
    apb(1, ADDR_LOCK, 0, 4'h1);
    apb(1, ADDR_CAP_A, 32'h0000_0A05, 4'h1);
    apb(0, ADDR_CAP_A, 0, 0);
    `CHK(rd, 32'h0000_0005)
    apb(0, 12'h030, 0, 0);
    `CHK({er, rd}, 33'h1_0000_0000)
  endtask
  // reset again mid-run; fields must return to all ones
  task automatic t_rerst();
    RST_N <= 0;
    repeat (3) @(posedge CLK);
    RST_N <= 1;
    repeat (3) @(posedge CLK);
    apb(0, ADDR_CAP_A, 0, 0);
    `CHK(rd, 32'h0000_1F1F)
    `CHK(MAPPING_LOCK, 1'b0)
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge CLK);
    RST_N <= 1;
    repeat (3) @(posedge CLK);
    t_regs();
    t_route();
    t_share();
    t_lock();
    t_rerst();
    print_verdict();
  end
  // watchdog well beyond the 73 transfers above
  initial
  begin
    repeat (20000) @(posedge CLK);
    miscompares++;
    print_verdict();
  end
endmodule
`default_nettype wire
